// ===== rtl/ppfs_pkg.sv
package ppfs_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int STATE_TIME_NS = 20;
    localparam int STATE_CYC =
        (STATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRETCH_STATES = 16;
    localparam int STRETCH_CYC = STRETCH_STATES * STATE_CYC;
    localparam int BLANK_CYC = 3;
    localparam logic [7:0] A_PORT_ONE = 8'h0F;
    localparam logic [7:0] A_PORT_TWO = 8'h10;
    localparam logic [7:0] A_SERIAL_CTL = 8'h11;
    localparam logic [7:0] A_SECOND_MASK = 8'h13;
    localparam logic [7:0] A_FAST_MASK = 8'h14;
    localparam logic [7:0] A_IOC_ZERO = 8'h15;
    localparam logic [7:0] A_IOC_ONE = 8'h16;
    localparam logic [7:0] A_IOC_TWO = 8'h17;
    localparam logic [7:0] A_IOC_THREE = 8'h18;
    localparam logic [7:0] A_DUTY_B = 8'h19;
    localparam logic [7:0] A_DUTY_C = 8'h1A;
    localparam logic [7:0] A_STATUS = 8'h1B;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PORT_ONE = 8'hFF;
    localparam int B_MASK_EN = 0;
    localparam int B_HSI_EN = 0;
    localparam int B_T2_A = 3;
    localparam int B_T2_B = 5;
    localparam int B_EXT_SEL = 1;
    localparam int B_TXD_SEL = 5;
    localparam int B_PWM_FREQ = 2;
    localparam int B_PWM_B = 2;
    localparam int B_PWM_C = 3;
    localparam int B_RXD_SEL = 3;
    localparam int N_IN = 14;
    localparam int I_ALT = 13;
    localparam int I_HSI = 12;
    localparam int I_P22 = 11;
    localparam int I_P21 = 10;
    localparam int I_RST = 9;
    localparam int I_ICT = 8;
    localparam logic [1:0] SER_MODE0 = 2'h0;
    localparam logic [5:0] STRETCH_LAST = 6'(STRETCH_CYC - 1);
    localparam logic [5:0] BLANK_LAST = 6'(BLANK_CYC - 1);
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ppfs_bus_req_t;
    typedef struct packed {
        logic second_ext;
        logic primary_ext;
        logic fast_in_zero;
    } ppfs_irq_t;
    typedef enum logic [2:0] {
        RS_IDLE  = 3'b001,
        RS_DRIVE = 3'b010,
        RS_BLANK = 3'b100
    } ppfs_rst_state_t;
endpackage

// ===== rtl/ppfs_pin_select.sv
`timescale 1ns/1ps
`default_nettype none
module ppfs_pin_select (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire ppfs_pkg::ppfs_bus_req_t bus_req,
    output var  logic [7:0]             rd_data,
    output var  ppfs_pkg::ppfs_irq_t    irq_pulse,
    output var  logic                   wake_up,
    output var  logic                   fast_capture,
    output var  logic                   second_timer_clear,
    output var  logic                   test_mode,
    output var  logic                   core_reset_n,
    input  wire logic                   power_down,
    input  wire logic                   ext_irq_alt_pin,
    input  wire logic                   fast_input_zero,
    input  wire logic                   port_two_bit_two,
    input  wire logic                   port_two_bit_one_in,
    output var  logic                   port_two_bit_one_out,
    output var  logic                   port_two_bit_one_oe,
    output var  logic                   port_two_bit_zero,
    input  wire logic                   reset_line_in,
    output var  logic                   reset_line_out,
    output var  logic                   reset_line_oe,
    input  wire logic                   in_circuit_test_strap,
    input  wire logic [7:0]             port_one_in,
    output var  logic [7:0]             port_one_out,
    output var  logic [7:0]             port_one_oe,
    input  wire logic [1:0]             serial_mode,
    input  wire logic                   uart_txd,
    input  wire logic                   uart_shift_clk,
    input  wire logic                   uart_rxd_drive,
    output var  logic                   serial_rx_data
);
    import ppfs_pkg::*;

    function automatic logic rise(input logic now, input logic prev);
        rise = now & ~prev;
    endfunction

    // ************************************************************
    // Input synchronisers.
    // ************************************************************
    logic [N_IN-1:0] in_s1_reg;
    logic [N_IN-1:0] in_s2_reg;
    logic [N_IN-1:0] in_s3_reg;
    logic [N_IN-1:0] pins;
    assign pins = {ext_irq_alt_pin, fast_input_zero, port_two_bit_two,
                   port_two_bit_one_in, reset_line_in,
                   in_circuit_test_strap, port_one_in};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            in_s1_reg <= '0;
            in_s2_reg <= '0;
            in_s3_reg <= '0;
        end else begin
            in_s1_reg <= pins;
            in_s2_reg <= in_s1_reg;
            in_s3_reg <= in_s2_reg;
        end
    end

    // ************************************************************
    // Register file.
    // ************************************************************
    logic [7:0] port_one_reg;
    logic       port_two_reg;
    logic [7:0] serial_port_control;
    logic [7:0] second_irq_mask_reg;
    logic [7:0] fast_irq_mask_reg;
    logic [7:0] io_control_zero;
    logic [7:0] io_control_one;
    logic [7:0] io_control_two;
    logic [7:0] io_control_three;
    logic [7:0] pulse_b_duty_reg;
    logic [7:0] pulse_c_duty_reg;
    logic [7:0] quasi_kick_reg;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic       test_mode_reg;
    ppfs_rst_state_t rst_state_reg;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            port_one_reg        <= RST_PORT_ONE;
            port_two_reg        <= 1'b1;
            serial_port_control <= RST_ZERO;
            second_irq_mask_reg <= RST_ZERO;
            fast_irq_mask_reg   <= RST_ZERO;
            io_control_zero     <= RST_ZERO;
            io_control_one      <= RST_ZERO;
            io_control_two      <= RST_ZERO;
            io_control_three    <= RST_ZERO;
            pulse_b_duty_reg    <= RST_ZERO;
            pulse_c_duty_reg    <= RST_ZERO;
            quasi_kick_reg      <= RST_ZERO;
        end else begin
            quasi_kick_reg <= RST_ZERO;
            if (bus_req.wr) begin
                case (bus_req.addr)
                    A_PORT_ONE: begin
                        port_one_reg   <= bus_req.wdata;
                        quasi_kick_reg <= bus_req.wdata & ~port_one_reg;
                    end
                    A_PORT_TWO:    port_two_reg <= bus_req.wdata[0];
                    A_SERIAL_CTL:  serial_port_control <= bus_req.wdata;
                    A_SECOND_MASK: second_irq_mask_reg <= bus_req.wdata;
                    A_FAST_MASK:   fast_irq_mask_reg <= bus_req.wdata;
                    A_IOC_ZERO:    io_control_zero <= bus_req.wdata;
                    A_IOC_ONE:     io_control_one <= bus_req.wdata;
                    A_IOC_TWO:     io_control_two <= bus_req.wdata;
                    A_IOC_THREE:   io_control_three <= bus_req.wdata;
                    A_DUTY_B:      pulse_b_duty_reg <= bus_req.wdata;
                    A_DUTY_C:      pulse_c_duty_reg <= bus_req.wdata;
                    default: begin
                    end
                endcase
            end
        end
    end

    always_comb begin
        case (bus_req.addr)
            A_PORT_ONE:    rd_data_next = in_s2_reg[7:0];
            A_PORT_TWO:    rd_data_next = {5'h00, in_s2_reg[I_P22],
                                           in_s2_reg[I_P21], port_two_reg};
            A_SERIAL_CTL:  rd_data_next = serial_port_control;
            A_SECOND_MASK: rd_data_next = second_irq_mask_reg;
            A_FAST_MASK:   rd_data_next = fast_irq_mask_reg;
            A_IOC_ZERO:    rd_data_next = io_control_zero;
            A_IOC_ONE:     rd_data_next = io_control_one;
            A_IOC_TWO:     rd_data_next = io_control_two;
            A_IOC_THREE:   rd_data_next = io_control_three;
            A_DUTY_B:      rd_data_next = pulse_b_duty_reg;
            A_DUTY_C:      rd_data_next = pulse_c_duty_reg;
            A_STATUS:      rd_data_next = {5'h00, rst_state_reg == RS_IDLE,
                                           core_reset_n, test_mode_reg};
            default:       rd_data_next = RST_ZERO;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_data_reg <= RST_ZERO;
        end else begin
            rd_data_reg <= bus_req.rd ? rd_data_next : RST_ZERO;
        end
    end
    assign rd_data = rd_data_reg;

    // ************************************************************
    // Interrupt and event detection.
    // ************************************************************
    logic p22_rise;
    logic alt_rise;
    logic hsi_rise;
    logic prim_level;
    assign p22_rise = rise(in_s2_reg[I_P22], in_s3_reg[I_P22]);
    assign alt_rise = rise(in_s2_reg[I_ALT], in_s3_reg[I_ALT]);
    assign hsi_rise = rise(in_s2_reg[I_HSI], in_s3_reg[I_HSI]);
    assign prim_level = io_control_one[B_EXT_SEL] ? in_s2_reg[I_ALT]
                                                  : in_s2_reg[I_P22];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_pulse          <= '0;
            wake_up            <= 1'b0;
            fast_capture       <= 1'b0;
            second_timer_clear <= 1'b0;
        end else begin
            irq_pulse.second_ext <= p22_rise
                                    & second_irq_mask_reg[B_MASK_EN];
            irq_pulse.primary_ext <= io_control_one[B_EXT_SEL] ? alt_rise
                                                               : p22_rise;
            irq_pulse.fast_in_zero <= hsi_rise
                                      & fast_irq_mask_reg[B_MASK_EN];
            wake_up <= power_down & prim_level;
            fast_capture <= hsi_rise & io_control_zero[B_HSI_EN];
            second_timer_clear <= hsi_rise & io_control_zero[B_T2_A]
                                  & io_control_zero[B_T2_B];
        end
    end

    // ************************************************************
    // Reset line stretcher and test strap.
    // ************************************************************
    logic [5:0] rst_cnt_reg;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rst_state_reg <= RS_IDLE;
            rst_cnt_reg   <= 6'h00;
            reset_line_oe <= 1'b0;
        end else begin
            case (rst_state_reg)
                RS_IDLE: begin
                    if (!in_s2_reg[I_RST]) begin
                        rst_state_reg <= RS_DRIVE;
                        rst_cnt_reg   <= STRETCH_LAST;
                        reset_line_oe <= 1'b1;
                    end
                end
                RS_DRIVE: begin
                    if (rst_cnt_reg == 6'h00) begin
                        rst_state_reg <= RS_BLANK;
                        rst_cnt_reg   <= BLANK_LAST;
                        reset_line_oe <= 1'b0;
                    end else begin
                        rst_cnt_reg <= rst_cnt_reg - 6'h01;
                    end
                end
                RS_BLANK: begin
                    if (rst_cnt_reg == 6'h00) begin
                        rst_state_reg <= RS_IDLE;
                    end else begin
                        rst_cnt_reg <= rst_cnt_reg - 6'h01;
                    end
                end
                default: begin
                    rst_state_reg <= RS_IDLE;
                    reset_line_oe <= 1'b0;
                end
            endcase
        end
    end

    logic core_release;
    assign core_release = (rst_state_reg == RS_IDLE) & in_s2_reg[I_RST];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            core_reset_n   <= 1'b0;
            test_mode_reg  <= 1'b0;
            reset_line_out <= 1'b0;
        end else begin
            core_reset_n <= core_release;
            if (core_release && !core_reset_n) begin
                test_mode_reg <= ~in_s2_reg[I_ICT];
            end
        end
    end
    assign test_mode = test_mode_reg;

    // ************************************************************
    // Pulse width channels.
    // ************************************************************
    logic [7:0] pwm_cnt_reg;
    logic       pwm_pre_reg;
    logic       pwm_b_reg;
    logic       pwm_c_reg;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pwm_cnt_reg <= RST_ZERO;
            pwm_pre_reg <= 1'b0;
            pwm_b_reg   <= 1'b0;
            pwm_c_reg   <= 1'b0;
        end else begin
            pwm_pre_reg <= ~pwm_pre_reg;
            if (!io_control_two[B_PWM_FREQ] || pwm_pre_reg) begin
                pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
            end
            pwm_b_reg <= pwm_cnt_reg < pulse_b_duty_reg;
            pwm_c_reg <= pwm_cnt_reg < pulse_c_duty_reg;
        end
    end

    // ************************************************************
    // Pin drivers.
    // ************************************************************
    logic [7:0] p1_alt;
    logic [7:0] p1_alt_val;
    assign p1_alt = {3'h0, io_control_three[B_PWM_C],
                     io_control_three[B_PWM_B], 3'h0};
    assign p1_alt_val = {3'h0, pwm_c_reg, pwm_b_reg, 3'h0};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            port_one_out         <= RST_PORT_ONE;
            port_one_oe          <= RST_ZERO;
            port_two_bit_zero    <= 1'b1;
            port_two_bit_one_out <= 1'b0;
            port_two_bit_one_oe  <= 1'b0;
            serial_rx_data       <= 1'b1;
        end else begin
            port_one_out <= (p1_alt & p1_alt_val)
                            | (~p1_alt & port_one_reg);
            port_one_oe <= p1_alt | ~port_one_reg | quasi_kick_reg;
            if (io_control_one[B_TXD_SEL]) begin
                port_two_bit_zero <= (serial_mode == SER_MODE0)
                                     ? uart_shift_clk : uart_txd;
            end else begin
                port_two_bit_zero <= port_two_reg;
            end
            port_two_bit_one_oe <= serial_port_control[B_RXD_SEL]
                                   & (serial_mode == SER_MODE0)
                                   & ~uart_rxd_drive;
            serial_rx_data <= serial_port_control[B_RXD_SEL]
                              ? in_s2_reg[I_P21] : 1'b1;
        end
    end

    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    int unsigned oe_run;
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !reset_line_oe) begin
            oe_run <= 0;
        end else begin
            oe_run <= oe_run + 1;
        end
    end

    sequence s_p22_rise;
        !port_two_bit_two ##1 port_two_bit_two [*2];
    endsequence
    sequence s_hsi_rise;
        !fast_input_zero ##1 fast_input_zero [*2];
    endsequence

    a_second_irq_path: assert property (
        (s_p22_rise ##0 second_irq_mask_reg[B_MASK_EN]) ##1
        second_irq_mask_reg[B_MASK_EN] |-> ##1 irq_pulse.second_ext)
        else $error("second interrupt missed");
    a_second_irq_mask: assert property (
        !second_irq_mask_reg[B_MASK_EN] |=> !irq_pulse.second_ext)
        else $error("masked second interrupt raised");
    a_primary_irq_path: assert property (
        (s_p22_rise ##0 !io_control_one[B_EXT_SEL]) ##1
        !io_control_one[B_EXT_SEL] |-> ##1 irq_pulse.primary_ext)
        else $error("primary interrupt missed");
    a_wake_from_down: assert property (
        (!io_control_one[B_EXT_SEL] && port_two_bit_two && power_down) [*3]
        |-> ##1 wake_up)
        else $error("no wake from power down");
    a_reset_stretch_len: assert property (
        $fell(reset_line_oe) |-> oe_run == STRETCH_CYC)
        else $error("reset stretch length wrong");
    a_rx_pin_select: assert property (
        !serial_port_control[B_RXD_SEL] |=> serial_rx_data && !port_two_bit_one_oe)
        else $error("receive line not idle in port mode");
    a_tx_pin_route: assert property (
        io_control_one[B_TXD_SEL] && serial_mode != SER_MODE0
        |=> port_two_bit_zero == $past(uart_txd))
        else $error("transmit not routed");
    a_strap_capture: assert property (
        $rose(core_reset_n) |-> test_mode == !$past(in_s2_reg[I_ICT]))
        else $error("test strap not captured");
    a_pwm_b_route: assert property (
        io_control_three[B_PWM_B] |=> port_one_oe[3]
        && port_one_out[3] == $past(pwm_b_reg))
        else $error("pulse b not routed");
    a_hsi_capture_path: assert property (
        (s_hsi_rise ##0 io_control_zero[B_HSI_EN]) ##1
        io_control_zero[B_HSI_EN] |-> ##1 fast_capture)
        else $error("fast input event not captured");
    a_timer_clear_gate: assert property (
        !(io_control_zero[B_T2_A] && io_control_zero[B_T2_B])
        |=> !second_timer_clear)
        else $error("timer clear while disabled");
endmodule
`default_nettype wire

// ===== test/ppfs_board.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Board side: pull-ups on the open-drain and quasi lines.
// ************************************************************
module ppfs_board (
    input  wire logic       reset_oe,
    input  wire logic       ext_low,
    output var  logic       reset_line,
    input  wire logic [7:0] p1_out,
    input  wire logic [7:0] p1_oe,
    output var  logic [7:0] p1_pin,
    input  wire logic       p21_oe,
    input  wire logic       p21_drive,
    output var  logic       p21_pin
);
    // The reset line is pulled up and pulled low by either party.
    assign reset_line = ~(reset_oe | ext_low);
    // Undriven port one lines float to the pull-up level.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            p1_pin[i] = p1_oe[i] ? p1_out[i] : 1'b1;
        end
    end
    // The receive line is open-drain: a driving device pulls it low.
    assign p21_pin = p21_oe ? 1'b0 : p21_drive;
endmodule
`default_nettype wire

// ===== test/port_pin_function_select_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Bench for the pin function select block.
// ************************************************************
module port_pin_function_select_bench;
    import ppfs_pkg::*;
    logic          clk_sys, rst_n, power_down, strap, ext_low, cnt_clr;
    logic [2:0]    pins;
    logic [1:0]    serial_mode;
    logic          uart_txd, uart_shift_clk, uart_rxd_drive, p21_drv;
    ppfs_bus_req_t bus_req;
    ppfs_irq_t     irq_pulse;
    logic [7:0]    rd_data, p1_out, p1_oe, p1_pin, got, d;
    logic          wake_up, fast_capture, t2_clr, test_mode, core_rst_n;
    logic          p21_in, p21_out, p21_oe, p20, rl_in, rl_out, rl_oe, rx_data;
    int            mismatches, checks_done, cycles, db, dc;
    int            cnt [8];
    ppfs_pin_select ppfs_pin_select_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req),
        .rd_data(rd_data), .irq_pulse(irq_pulse), .wake_up(wake_up),
        .fast_capture(fast_capture), .second_timer_clear(t2_clr), .test_mode(test_mode),
        .core_reset_n(core_rst_n), .power_down(power_down), .ext_irq_alt_pin(pins[2]),
        .fast_input_zero(pins[1]), .port_two_bit_two(pins[0]), .port_two_bit_one_in(p21_in),
        .port_two_bit_one_out(p21_out), .port_two_bit_one_oe(p21_oe),
        .port_two_bit_zero(p20), .reset_line_in(rl_in), .reset_line_out(rl_out),
        .reset_line_oe(rl_oe), .in_circuit_test_strap(strap), .port_one_in(p1_pin),
        .port_one_out(p1_out), .port_one_oe(p1_oe), .serial_mode(serial_mode),
        .uart_txd(uart_txd), .uart_shift_clk(uart_shift_clk),
        .uart_rxd_drive(uart_rxd_drive), .serial_rx_data(rx_data));
    ppfs_board ppfs_board_inst (.reset_oe(rl_oe), .ext_low(ext_low), .reset_line(rl_in),
        .p1_out(p1_out), .p1_oe(p1_oe), .p1_pin(p1_pin), .p21_oe(p21_oe),
        .p21_drive(p21_drv), .p21_pin(p21_in));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 12000) begin
            mismatches++;
            wrap_up();
        end
        if (cnt_clr) begin
            foreach (cnt[i]) cnt[i] <= 0;
        end else begin
            cnt[0] <= cnt[0] + irq_pulse.second_ext;
            cnt[1] <= cnt[1] + irq_pulse.primary_ext;
            cnt[2] <= cnt[2] + irq_pulse.fast_in_zero;
            cnt[3] <= cnt[3] + rl_oe;
            cnt[4] <= cnt[4] + fast_capture;
            cnt[5] <= cnt[5] + t2_clr;
            cnt[6] <= cnt[6] + p1_pin[3];
            cnt[7] <= cnt[7] + p1_pin[4];
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys) bus_req <= '{a, v, 1'b1, 1'b0};
        @(posedge clk_sys) bus_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys) bus_req <= '0;
        #1 got = rd_data;
    endtask
    task automatic clr();
        @(posedge clk_sys) cnt_clr <= 1'b1;
        @(posedge clk_sys) cnt_clr <= 1'b0;
    endtask
    task automatic pulse(input int i, input int len);
        @(posedge clk_sys) pins[i] <= 1'b1;
        tick(len);
        pins[i] <= 1'b0;
        tick(8);
    endtask
    task automatic line_pulse(input int len);
        if (len > 0) begin
            @(posedge clk_sys) ext_low <= 1'b1;
            tick(len);
        end
        ext_low <= 1'b0;
        tick(4);
        for (int k = 0; k < 300 && core_rst_n !== 1'b1; k++) tick(1);
        tick(2);
    endtask
    function automatic int exp_hi(input int duty, input int div);
        return duty * div;
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        {rst_n, power_down, cnt_clr, pins, uart_shift_clk} = '0;
        {strap, ext_low, uart_txd, uart_rxd_drive, p21_drv} = '1;
        serial_mode = 2'h1;
        bus_req = '0;
        {mismatches, checks_done, cycles} = '0;
        db = $urandom(23);
        tick(2);
        rst_n <= 1'b1;
        tick(40);
        line_pulse(0);
        clr();
        line_pulse(2);
        chk("stretch", 16'(cnt[3]), 16'(STRETCH_CYC));
        chk("od outs", {p21_out, rl_out}, 2'h0);
        strap <= 1'b0;
        line_pulse(2);
        chk("test_mode", test_mode, 1'b1);
        rd(A_STATUS);
        chk("status", got, 8'h07);
        strap <= 1'b1;
        line_pulse(2);
        chk("test_mode", test_mode, 1'b0);
        rd(8'h40);
        chk("unmapped", got, 8'h00);
        wr(A_SECOND_MASK, 8'h01);
        wr(A_FAST_MASK, 8'h01);
        wr(A_IOC_ZERO, 8'h29);
        for (int m = 1; m >= 0; m--) begin
            wr(A_SECOND_MASK, 8'(m));
            clr();
            pulse(0, 4);
            chk("second", 16'(cnt[0]), 16'(m));
            chk("primary", 16'(cnt[1]), 16'h1);
        end
        wr(A_IOC_ONE, 8'h02);
        clr();
        pulse(0, 4);
        pulse(2, 4);
        chk("primary alt", 16'(cnt[1]), 16'h1);
        pulse(1, 4);
        chk("fast irq", 16'(cnt[2]), 16'h1);
        chk("capture", 16'(cnt[4]), 16'h1);
        chk("t2 clear", 16'(cnt[5]), 16'h1);
        wr(A_IOC_ZERO, 8'h08);
        wr(A_FAST_MASK, 8'h00);
        clr();
        pulse(1, 4);
        chk("gated", 16'(cnt[2] + cnt[4] + cnt[5]), 16'h0);
        wr(A_IOC_ONE, 8'h00);
        @(posedge clk_sys) power_down <= 1'b1;
        pins[0] <= 1'b1;
        tick(4);
        chk("wake", wake_up, 1'b1);
        power_down <= 1'b0;
        pins[0] <= 1'b0;
        repeat (4) begin
            d = 8'($urandom);
            wr(A_PORT_TWO, d);
            p21_drv <= d[7];
            tick(4);
            chk("p20 port", p20, d[0]);
            chk("rx idle", rx_data, 1'b1);
            rd(A_PORT_TWO);
            chk("p2 read", got[1:0], {d[7], d[0]});
            wr(A_IOC_ONE, 8'h20);
            serial_mode <= d[2:1];
            uart_txd <= d[3];
            uart_shift_clk <= d[4];
            tick(4);
            chk("txd pin", p20, (d[2:1] == SER_MODE0) ? d[4] : d[3]);
            wr(A_SERIAL_CTL, 8'h08);
            uart_rxd_drive <= d[5];
            tick(5);
            chk("rx oe", p21_oe, (d[2:1] == SER_MODE0) && !d[5]);
            chk("rx data", rx_data, ((d[2:1] == SER_MODE0) && !d[5]) ? 1'b0 : d[7]);
            uart_rxd_drive <= 1'b1;
            serial_mode <= 2'h1;
            wr(A_SERIAL_CTL, 8'h00);
            wr(A_IOC_ONE, 8'h00);
        end
        d = 8'($urandom);
        wr(A_PORT_ONE, d);
        tick(3);
        rd(A_PORT_ONE);
        chk("port one", got, d);
        chk("p1 pins", p1_pin[4:3], d[4:3]);
        db = $urandom_range(1, 254);
        dc = $urandom_range(1, 254);
        wr(A_DUTY_B, 8'(db));
        wr(A_DUTY_C, 8'(dc));
        wr(A_IOC_THREE, 8'h0C);
        for (int div = 1; div <= 2; div++) begin
            wr(A_IOC_TWO, (div == 2) ? 8'h04 : 8'h00);
            tick(600);
            clr();
            tick(256 * div + 1);
            chk("pwm b", 16'(cnt[6]), 16'(exp_hi(db, div)));
            chk("pwm c", 16'(cnt[7]), 16'(exp_hi(dc, div)));
        end
        wrap_up();
    end
endmodule
`default_nettype wire
